// file: core/lkes_status.sv
// Legacy keyboard controller emulation status word and port side effects.
// Each status flag is its own flop; reserved bits 31:8 are not stored.
// The interrupt line routing sits in a small submodule.
// Assumes I/O cycle strobes and memory register strobes are one-cycle pulses
// synchronous to CORE_CLK_I; control bits come from the emulation control register.
// Operation
// RQ1: port 64h read returns status word
// RQ2: status readable, writable at offset 10Ch
// RQ3: memory access has no side effects
// RQ4: 60h write clears, 64h sets bit 3
// RQ5: port writes set bit 1 except A20
// RQ6: input full and enabled raises interrupt
// RQ7: port 60h read clears bit 0
// RQ8: output empty with pending raises interrupt
// RQ9: pointer line needs aux, full, enable
// RQ10: aux flag selects pointer or keyboard
// RQ11: bit 7 holds parity error
// RQ12: bit 6 holds time-out
// RQ13: bit 4 keyboard inhibit switch
// RQ14: bit 2 software warm/cold flag
// RQ15: port 64h read changes nothing
// RQ16: port 60h read returns output byte
// RQ17: port writes captured into input byte
// RQ18: upper bits zero, reset to zero
// RQ19: port event beats memory write
`timescale 1ns/1ps
`include "lkes_defs.svh"
module lkes_status (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_I,
   // Legacy I/O port cycles
   input  wire logic        IO_RD_I,
   input  wire logic        IO_WR_I,
   input  wire logic [7:0]  IO_ADDR_I,
   input  wire logic [7:0]  IO_WDATA_I,
   input  wire logic        IO_A20_SEQ_I,
   output logic      [7:0]  IO_RDATA_O,
   output logic             IO_RVALID_O,
   // Memory-mapped operational register access
   input  wire logic        MEM_RD_I,
   input  wire logic        MEM_WR_I,
   input  wire logic [11:0] MEM_ADDR_I,
   input  wire logic [31:0] MEM_WDATA_I,
   output logic      [31:0] MEM_RDATA_O,
   // Emulation control bits and data registers
   input  wire logic        EMUL_EN_I,
   input  wire logic        LEGACY_IRQ_ENABLE_I,
   input  wire logic        CHAR_PENDING_I,
   input  wire logic [7:0]  LEGACY_OUTPUT_BYTE_I,
   output logic      [7:0]  LEGACY_INPUT_BYTE_O,
   output logic             LEGACY_INPUT_WE_O,
   // Interrupt outputs and status word
   output logic             EMUL_IRQ_O,
   output logic             KEYBOARD_IRQ_LINE_O,
   output logic             POINTER_IRQ_LINE_O,
   output logic      [7:0]  STATUS_O
);
   // Status word and per-flag parts
   lkes_pkg::lkes_byte_t status_q;
   lkes_pkg::lkes_byte_t mem_merged;
   logic                 out_full_d;
   logic                 in_full_d;
   logic                 flag_d;
   logic                 cmd_data_d;
   logic                 keyboard_inhibit_switch_d;
   logic                 aux_full_d;
   logic                 timeout_d;
   logic                 parity_d;
   logic                 out_full_q;
   logic                 in_full_q;
   logic                 flag_q;
   logic                 cmd_data_q;
   logic                 keyboard_inhibit_switch_q;
   logic                 aux_full_q;
   logic                 timeout_q;
   logic                 parity_q;

   // Port write capture and port and memory read paths
   lkes_pkg::lkes_byte_t in_byte_q;
   lkes_pkg::lkes_byte_t io_rdata_q;
   lkes_pkg::lkes_byte_t io_rdata_d;
   logic                 io_rvalid_q;
   logic                 in_we_q;
   logic [31:0]          mem_rdata_q;
   logic [31:0]          mem_rdata_d;

   // Emulation interrupt conditions
   logic                 emul_irq_q;
   logic                 irq_in_full;
   logic                 irq_out_empty;

   wire hit_data   = (IO_ADDR_I == `LKES_PORT_DATA);
   wire hit_cmd    = (IO_ADDR_I == `LKES_PORT_CMD);
   wire port_wr    = IO_WR_I & EMUL_EN_I & (hit_data | hit_cmd);
   wire wr_data    = port_wr & hit_data;
   wire wr_cmd     = port_wr & hit_cmd;
   wire rd_data    = IO_RD_I & EMUL_EN_I & hit_data;
   wire rd_cmd     = IO_RD_I & EMUL_EN_I & hit_cmd;
   // RQ2: status offset decode
   wire mem_hit    = (MEM_ADDR_I == `LKES_STATUS_OFFSET);
   wire mem_wr_hit = MEM_WR_I & mem_hit;
   wire mem_rd_hit = MEM_RD_I & mem_hit;

   // RQ3: memory write stores value only
   assign mem_merged = mem_wr_hit ? MEM_WDATA_I[7:0] : status_q;

   // RQ15: 64h read sets and clears nothing
   wire set_cmd_data = wr_cmd;
   wire clr_cmd_data = wr_data;
   wire set_in_full  = port_wr & ~IO_A20_SEQ_I;
   wire clr_out_full = rd_data;

   // RQ19: port effects override memory write
   // RQ7: output full cleared
   assign out_full_d = clr_out_full ? 1'b0 : mem_merged[`LKES_BIT_OUT_FULL];

   // RQ5: input full set except A20
   assign in_full_d  = set_in_full ? 1'b1 : mem_merged[`LKES_BIT_IN_FULL];

   // RQ14: flag stored only
   assign flag_d     = mem_merged[`LKES_BIT_FLAG];

   // RQ4: command versus data
   assign cmd_data_d = set_cmd_data | (~clr_cmd_data & mem_merged[`LKES_BIT_CMD_DATA]);

   // RQ13: inhibit switch stored
   assign keyboard_inhibit_switch_d   = mem_merged[`LKES_BIT_KEYBOARD_INHIBIT_SWITCH];

   // Auxiliary output full stored
   assign aux_full_d = mem_merged[`LKES_BIT_AUX_FULL];

   // RQ12: time-out stored
   assign timeout_d  = mem_merged[`LKES_BIT_TIMEOUT];

   // RQ11: parity error stored
   assign parity_d   = mem_merged[`LKES_BIT_PARITY];

   // One flop per status flag
   // RQ7: output full flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         out_full_q <= `LKES_FLAG_RESET;
      end else begin
         out_full_q <= out_full_d;
      end
   end

   // RQ5: input full flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         in_full_q <= `LKES_FLAG_RESET;
      end else begin
         in_full_q <= in_full_d;
      end
   end

   // RQ14: software flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         flag_q <= `LKES_FLAG_RESET;
      end else begin
         flag_q <= flag_d;
      end
   end

   // RQ4: command versus data flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cmd_data_q <= `LKES_FLAG_RESET;
      end else begin
         cmd_data_q <= cmd_data_d;
      end
   end

   // RQ13: inhibit switch flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         keyboard_inhibit_switch_q <= `LKES_FLAG_RESET;
      end else begin
         keyboard_inhibit_switch_q <= keyboard_inhibit_switch_d;
      end
   end

   // RQ9: auxiliary output full flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         aux_full_q <= `LKES_FLAG_RESET;
      end else begin
         aux_full_q <= aux_full_d;
      end
   end

   // RQ12: time-out flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         timeout_q <= `LKES_FLAG_RESET;
      end else begin
         timeout_q <= timeout_d;
      end
   end

   // RQ11: parity error flag
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         parity_q <= `LKES_FLAG_RESET;
      end else begin
         parity_q <= parity_d;
      end
   end

   // RQ18: upper bits absent, flags reset zero
   assign status_q = {parity_q, timeout_q, aux_full_q, keyboard_inhibit_switch_q,
                      cmd_data_q, flag_q, in_full_q, out_full_q};

   // RQ17: capture port write data
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         in_byte_q <= `LKES_BYTE_RESET;
      end else if (port_wr) begin
         in_byte_q <= IO_WDATA_I;
      end
   end

   // Input register write pulse
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         in_we_q <= `LKES_FLAG_RESET;
      end else begin
         in_we_q <= port_wr;
      end
   end

   // Accepted port read
   wire rd_any = rd_cmd | rd_data;
   // RQ1: port 64h returns status
   // RQ16: port 60h returns output byte
   assign io_rdata_d = rd_cmd ? status_q : LEGACY_OUTPUT_BYTE_I;

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         io_rdata_q <= `LKES_BYTE_RESET;
      end else if (rd_any) begin
         io_rdata_q <= io_rdata_d;
      end
   end

   // Read valid pulse
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         io_rvalid_q <= `LKES_FLAG_RESET;
      end else begin
         io_rvalid_q <= rd_any;
      end
   end

   // RQ18: upper bits read zero
   wire [31:0] mem_rd_word = {24'h00_0000, status_q};
   assign mem_rdata_d = mem_rd_hit ? mem_rd_word : 32'h0000_0000;

   // RQ2: memory read data held between reads
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mem_rdata_q <= 32'h0000_0000;
      end else if (MEM_RD_I) begin
         mem_rdata_q <= mem_rdata_d;
      end
   end

   // RQ6: input full interrupt
   assign irq_in_full   = status_q[`LKES_BIT_IN_FULL] & EMUL_EN_I;

   // RQ8: output empty interrupt
   assign irq_out_empty = ~status_q[`LKES_BIT_OUT_FULL] & CHAR_PENDING_I;

   // Emulation interrupt condition
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         emul_irq_q <= `LKES_FLAG_RESET;
      end else begin
         emul_irq_q <= irq_in_full | irq_out_empty;
      end
   end

   lkes_irq_route u_route (
      .CORE_CLK_I (CORE_CLK_I),
      .RST_I      (RST_I),
      .irq_en_i   (LEGACY_IRQ_ENABLE_I),
      .out_full_i (status_q[`LKES_BIT_OUT_FULL]),
      .aux_full_i (status_q[`LKES_BIT_AUX_FULL]),
      .kbd_irq_o  (KEYBOARD_IRQ_LINE_O),
      .ptr_irq_o  (POINTER_IRQ_LINE_O)
   );

   assign IO_RDATA_O          = io_rdata_q;
   assign IO_RVALID_O         = io_rvalid_q;
   assign MEM_RDATA_O         = mem_rdata_q;
   assign LEGACY_INPUT_BYTE_O = in_byte_q;
   assign LEGACY_INPUT_WE_O   = in_we_q;
   assign EMUL_IRQ_O          = emul_irq_q;
   assign STATUS_O            = status_q;
endmodule // lkes_status

// file: include/lkes_defs.svh
// Constants for the legacy keyboard emulation status block.
// Assumes inclusion by bare name from the include folder.
`ifndef LKES_DEFS_SVH
`define LKES_DEFS_SVH

`define LKES_STATUS_OFFSET   12'h10C
`define LKES_STATUS_RESET    8'h00
`define LKES_FLAG_RESET      1'b0
`define LKES_BYTE_RESET      8'h00
`define LKES_PORT_DATA       8'h60
`define LKES_PORT_CMD        8'h64
`define LKES_BIT_OUT_FULL    0
`define LKES_BIT_IN_FULL     1
`define LKES_BIT_FLAG        2
`define LKES_BIT_CMD_DATA    3
`define LKES_BIT_KEYBOARD_INHIBIT_SWITCH      4
`define LKES_BIT_AUX_FULL    5
`define LKES_BIT_TIMEOUT     6
`define LKES_BIT_PARITY      7

`endif

// file: include/lkes_pkg.sv
// Types for the legacy keyboard emulation status block.
// Assumes no surroundings beyond a SystemVerilog compiler.
package lkes_pkg;
   typedef logic [7:0] lkes_byte_t;
endpackage

// file: core/lkes_irq_route.sv
// Legacy interrupt line routing from status flags.
// Assumes all inputs are flip-flop outputs on the same clock.
`timescale 1ns/1ps
module lkes_irq_route (
   input  wire logic CORE_CLK_I,
   input  wire logic RST_I,
   input  wire logic irq_en_i,
   input  wire logic out_full_i,
   input  wire logic aux_full_i,
   output logic      kbd_irq_o,
   output logic      ptr_irq_o
);
   logic active;
   logic kbd_q;
   logic ptr_q;

   assign active = irq_en_i & out_full_i;

   // RQ9: pointer line select
   // RQ10: keyboard otherwise
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         kbd_q <= 1'b0;
         ptr_q <= 1'b0;
      end else begin
         kbd_q <= active & ~aux_full_i;
         ptr_q <= active & aux_full_i;
      end
   end

   assign kbd_irq_o = kbd_q;
   assign ptr_irq_o = ptr_q;
endmodule // lkes_irq_route

// file: tb/lkes_status_properties.sv
// Checker on the status block ports.
// Assumes binding to lkes_status.
`timescale 1ns/1ps
module lkes_status_props (
   input wire logic        CORE_CLK_I,
   input wire logic        RST_I,
   input wire logic        IO_RD_I,
   input wire logic        IO_WR_I,
   input wire logic [7:0]  IO_ADDR_I,
   input wire logic        IO_A20_SEQ_I,
   input wire logic [7:0]  IO_RDATA_O,
   input wire logic        IO_RVALID_O,
   input wire logic        MEM_RD_I,
   input wire logic [11:0] MEM_ADDR_I,
   input wire logic [31:0] MEM_RDATA_O,
   input wire logic        EMUL_EN_I,
   input wire logic        LEGACY_IRQ_ENABLE_I,
   input wire logic        CHAR_PENDING_I,
   input wire logic [7:0]  LEGACY_OUTPUT_BYTE_I,
   input wire logic        EMUL_IRQ_O,
   input wire logic        KEYBOARD_IRQ_LINE_O,
   input wire logic        POINTER_IRQ_LINE_O,
   input wire logic [7:0]  STATUS_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   wire d60 = EMUL_EN_I & (IO_ADDR_I == 8'h60);
   wire c64 = EMUL_EN_I & (IO_ADDR_I == 8'h64);
   AST_CD0: assert property (IO_WR_I & d60 |=> !STATUS_O[3]) else $error("cmd bit set");
   AST_CD1: assert property (IO_WR_I & c64 |=> STATUS_O[3]) else $error("cmd bit clear");
   AST_INF: assert property (IO_WR_I & (d60 | c64) & !IO_A20_SEQ_I |=> STATUS_O[1])
      else $error("input full not set");
   AST_RD64: assert property (IO_RD_I & c64 |=> IO_RVALID_O && IO_RDATA_O == $past(STATUS_O))
      else $error("status read wrong");
   AST_RD60: assert property (IO_RD_I & d60 |=>
      !STATUS_O[0] && IO_RDATA_O == $past(LEGACY_OUTPUT_BYTE_I)) else $error("data read wrong");
   AST_EIRQ: assert property (STATUS_O[1] & EMUL_EN_I |=> EMUL_IRQ_O) else $error("no irq");
   AST_CP: assert property (!STATUS_O[0] & CHAR_PENDING_I |=> EMUL_IRQ_O) else $error("no irq");
   AST_LINE: assert property (STATUS_O[0] & LEGACY_IRQ_ENABLE_I |=>
      POINTER_IRQ_LINE_O == $past(STATUS_O[5]) && KEYBOARD_IRQ_LINE_O != $past(STATUS_O[5]))
      else $error("irq line wrong");
   AST_OFF: assert property (IO_RD_I & !EMUL_EN_I |=> !IO_RVALID_O) else $error("read taken");
   AST_MEM: assert property (MEM_RD_I & MEM_ADDR_I == 12'h10C |=>
      MEM_RDATA_O == {24'h0, $past(STATUS_O)}) else $error("mem read wrong");
endmodule // lkes_status_props
bind lkes_status lkes_status_props i_props (.*);

// file: tb/lkes_host_model.sv
// Host side issuing single-cycle legacy port cycles.
// Assumes the bench calls cyc between clock edges.
`timescale 1ns/1ps
module lkes_host_model (
   input  wire logic       CORE_CLK_I,
   output logic            IO_RD_O,
   output logic            IO_WR_O,
   output logic      [7:0] IO_ADDR_O,
   output logic      [7:0] IO_WDATA_O,
   output logic            IO_A20_SEQ_O
);
   initial {IO_RD_O, IO_WR_O, IO_ADDR_O, IO_WDATA_O, IO_A20_SEQ_O} = 19'h0;
   // Released address and data lines show inverted values; strobes and A20 drop low
   task automatic cyc(input logic w, input logic [7:0] a, d, input logic s);
      @(posedge CORE_CLK_I);
      {IO_WR_O, IO_RD_O, IO_ADDR_O, IO_WDATA_O, IO_A20_SEQ_O} <= {w, !w, a, d, s};
      @(posedge CORE_CLK_I);
      {IO_WR_O, IO_RD_O, IO_ADDR_O, IO_WDATA_O, IO_A20_SEQ_O} <= {2'b00, ~a, ~d, 1'b0};
      #1;
   endtask
endmodule // lkes_host_model

// file: tb/lkes_status_tb_top.sv
// Bench for the status block with a host port model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module lkes_status_tb_top;
   logic        clk = 1'b0, rst = 1'b1, mem_rd = 1'b0, mem_wr = 1'b0;
   logic        emul_en = 1'b0, irq_en = 1'b0, cp = 1'b0;
   logic [11:0] mem_addr = 12'h0;
   logic [31:0] mem_wdata = 32'h0, mem_rdata;
   logic [7:0]  out_byte = 8'h0, io_rdata, in_byte, status, io_addr, io_wdata;
   logic        io_rd, io_wr, io_a20, io_rvalid, in_we, eirq, kirq, pirq;
   int          miscompares = 0, n_tests = 0;
   always #5 clk = ~clk;
   lkes_host_model i_host (.CORE_CLK_I(clk), .IO_RD_O(io_rd), .IO_WR_O(io_wr),
      .IO_ADDR_O(io_addr), .IO_WDATA_O(io_wdata), .IO_A20_SEQ_O(io_a20));
   lkes_status i_dut (.CORE_CLK_I(clk), .RST_I(rst), .IO_RD_I(io_rd), .IO_WR_I(io_wr),
      .IO_ADDR_I(io_addr), .IO_WDATA_I(io_wdata), .IO_A20_SEQ_I(io_a20),
      .IO_RDATA_O(io_rdata), .IO_RVALID_O(io_rvalid), .MEM_RD_I(mem_rd), .MEM_WR_I(mem_wr),
      .MEM_ADDR_I(mem_addr), .MEM_WDATA_I(mem_wdata), .MEM_RDATA_O(mem_rdata),
      .EMUL_EN_I(emul_en), .LEGACY_IRQ_ENABLE_I(irq_en), .CHAR_PENDING_I(cp),
      .LEGACY_OUTPUT_BYTE_I(out_byte), .LEGACY_INPUT_BYTE_O(in_byte),
      .LEGACY_INPUT_WE_O(in_we), .EMUL_IRQ_O(eirq), .KEYBOARD_IRQ_LINE_O(kirq),
      .POINTER_IRQ_LINE_O(pirq), .STATUS_O(status));
   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic mcyc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {mem_wr, mem_rd, mem_addr, mem_wdata} <= {w, !w, a, d};
      @(posedge clk);
      {mem_wr, mem_rd} <= 2'b00;
      #1;
   endtask
   task print_verdict;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1 chk(status, 0);
      mcyc(1, 12'h10C, 32'hFFFF_FFFF);
      mcyc(0, 12'h10C, 0);
      chk(mem_rdata, 32'h0000_00FF);
      mcyc(0, 12'h108, 0);
      chk(mem_rdata, 0);
      mcyc(1, 12'h10C, 32'hD4);
      chk(status, 8'hD4);
      $display("test registers done");
      @(posedge clk) emul_en <= 1'b1;
      i_host.cyc(1, 8'h60, 8'hA5, 0);
      chk({in_we, in_byte, status}, {1'b1, 8'hA5, 8'hD6});
      @(posedge clk) #1 chk(eirq, 1);
      i_host.cyc(1, 8'h64, 8'h3C, 0);
      chk(status, 8'hDE);
      mcyc(1, 12'h10C, 0);
      i_host.cyc(1, 8'h64, 8'h77, 1);
      chk(status, 8'h08);
      i_host.cyc(0, 8'h64, 0, 0);
      chk({io_rvalid, io_rdata, status}, {1'b1, 8'h08, 8'h08});
      $display("test ports done");
      @(posedge clk) {irq_en, out_byte} <= {1'b1, 8'h5A};
      mcyc(1, 12'h10C, 32'h21);
      @(posedge clk) #1 chk({pirq, kirq}, 2'b10);
      mcyc(1, 12'h10C, 32'h01);
      @(posedge clk) #1 chk({pirq, kirq}, 2'b01);
      i_host.cyc(0, 8'h60, 0, 0);
      chk({io_rdata, status}, {8'h5A, 8'h00});
      @(posedge clk) cp <= 1'b1;
      @(posedge clk) #1 chk(eirq, 1);
      $display("test interrupts done");
      fork
         i_host.cyc(1, 8'h60, 8'h11, 0);
         mcyc(1, 12'h10C, 0);
      join
      chk(status, 8'h02);
      @(posedge clk) emul_en <= 1'b0;
      i_host.cyc(0, 8'h64, 0, 0);
      chk(io_rvalid, 0);
      $display("test collisions done");
      print_verdict;
   end
endmodule // lkes_status_tb_top
